/* File: core/pms_pkg.sv */
// shared constants, types and switch bundle for the panel maintenance sequencer
package pms_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 17;
  localparam int MEM_WORDS_DEFAULT = 131072;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_DISPLAY = 8'h08;
  localparam logic [7:0] REG_IADDR   = 8'h0C;
  localparam logic [7:0] REG_FIRST_STATUS_WORD    = 8'h10;
  localparam logic [7:0] REG_SECOND_STATUS_WORD    = 8'h14;
  localparam logic [7:0] REG_AREG    = 8'h18;
  localparam logic [7:0] REG_BREG    = 8'h1C;

  localparam int CTRL_LOCK   = 0;
  localparam int STAT_IDLE   = 0;
  localparam int STAT_HALT   = 1;
  localparam int STAT_IO_SERVICE_CALL_FLAG   = 2;
  localparam int STAT_MCLR   = 3;
  localparam int STAT_RUN    = 4;

  // word bit n sits at vector index n
  localparam int P1_CC_LO    = 0;
  localparam int P1_FS       = 5;
  localparam int P1_FZ       = 6;
  localparam int P1_FNF      = 7;
  localparam int P1_SLAVE    = 8;
  localparam int P1_DM       = 10;
  localparam int P1_AM       = 11;
  localparam int P2_WK0      = 2;
  localparam int P2_WK1      = 3;
  localparam int P2_CI       = 5;
  localparam int P2_II       = 6;
  localparam int P2_EI       = 7;
  localparam int P2_RP_LO    = 24;
  localparam int P_FIELD_LO  = 15;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [16:0] ADDR_ZERO = 17'h0_0000;
  localparam logic [16:0] ADDR_ONE  = 17'h0_0001;

  typedef struct packed {
    logic [31:0] data_switch_outputs;
    logic [16:0] sel_addr;
    logic        data_enter;
    logic        data_clear;
    logic        store_instr_addr;
    logic        store_sel_addr;
    logic        display_instr_addr;
    logic        display_sel_addr;
    logic        insert_first_status_select;
    logic        insert_second_status_select;
    logic        panel_action_strobe_first;
    logic        panel_action_strobe_second;
    logic        address_hold_request;
    logic        address_increment_request;
    logic        compute_run;
    logic        compute_step;
    logic        cpu_reset_clear;
    logic        sys_reset_clear;
  } pms_sw_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [16:0] addr;
    logic [31:0] wdata;
  } pms_mem_s;

  typedef struct packed {
    logic [3:0] condition_code_bits;
    logic       float_significance_bit;
    logic       float_zero_bit;
    logic       float_normalize_bit;
    logic       slave_mode_bit;
    logic       decimal_mask_bit;
    logic       arith_mask_bit;
    logic       write_key_bit_zero;
    logic       write_key_bit_one;
    logic       counter_inhibit_bit;
    logic       io_inhibit_bit;
    logic       external_inhibit_bit;
    logic [3:0] register_pointer_field;
  } pms_psw_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PH3, ST_PH4, ST_PH5, ST_PH6, ST_PH1, ST_MEM, ST_FETCH, ST_CLR, ST_EXEC
  } pms_state_e;
endpackage

/* File: core/pms_sequencer.sv */
// maintenance panel sequencer: idle phase, insert, enter/clear, store, display, clear memory
//
// Register access over APB and the register addresses were decided locally.
module pms_sequencer #(
  parameter int MEM_WORDS = pms_pkg::MEM_WORDS_DEFAULT
) (
  input  wire logic             I_CLK_SYS,
  input  wire logic             I_RST,
  input  wire logic             I_PSEL,
  input  wire logic             I_PENABLE,
  input  wire logic             I_PWRITE,
  input  wire logic [7:0]       I_PADDR,
  input  wire logic [31:0]      I_PWDATA,
  output logic [31:0]           O_PRDATA,
  output logic                  O_PREADY,
  output logic                  O_PSLVERR,
  input  wire pms_pkg::pms_sw_s I_SW,
  input  wire logic             I_IO_FUNCTION_STROBE,
  input  wire logic             I_IO_SERVICE_CALL,
  input  wire logic             I_HALT_REQ,
  input  wire logic             I_EXEC_DONE,
  output logic                  O_EXEC_START,
  output logic [31:0]           O_EXEC_INSTR,
  output pms_pkg::pms_mem_s     O_MEM,
  input  wire logic             I_MEM_ACK,
  input  wire logic [31:0]      I_MEM_RDATA,
  output logic [31:0]           O_DISPLAY,
  output logic [16:0]           O_INSTR_ADDR,
  output logic                  O_HALT,
  output logic                  O_MEM_CLEAR,
  output logic                  O_IDLE_PHASE
);
  function automatic logic [31:0] first_status_word_word(input pms_pkg::pms_psw_s s);
    logic [31:0] w;
    w = pms_pkg::ZERO_WORD;
    w[pms_pkg::P1_CC_LO +: 4] = s.condition_code_bits;
    w[pms_pkg::P1_FS]    = s.float_significance_bit;
    w[pms_pkg::P1_FZ]    = s.float_zero_bit;
    w[pms_pkg::P1_FNF]   = s.float_normalize_bit;
    w[pms_pkg::P1_SLAVE] = s.slave_mode_bit;
    w[pms_pkg::P1_DM]    = s.decimal_mask_bit;
    w[pms_pkg::P1_AM]    = s.arith_mask_bit;
    return w;
  endfunction

  function automatic logic [31:0] second_status_word_word(input pms_pkg::pms_psw_s s);
    logic [31:0] w;
    w = pms_pkg::ZERO_WORD;
    w[pms_pkg::P2_WK0] = s.write_key_bit_zero;
    w[pms_pkg::P2_WK1] = s.write_key_bit_one;
    w[pms_pkg::P2_CI]  = s.counter_inhibit_bit;
    w[pms_pkg::P2_II]  = s.io_inhibit_bit;
    w[pms_pkg::P2_EI]  = s.external_inhibit_bit;
    w[pms_pkg::P2_RP_LO +: 4] = s.register_pointer_field;
    return w;
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    return a inside {pms_pkg::REG_CTRL, pms_pkg::REG_STATUS, pms_pkg::REG_DISPLAY,
                     pms_pkg::REG_IADDR, pms_pkg::REG_FIRST_STATUS_WORD, pms_pkg::REG_SECOND_STATUS_WORD,
                     pms_pkg::REG_AREG, pms_pkg::REG_BREG};
  endfunction

  localparam logic [16:0] LAST_ADDR = 17'(MEM_WORDS - 1);

  // switch synchroniser: three stages, a bit changes once stages two and three agree
  pms_pkg::pms_sw_s sw_q1, sw_q2, sw_q3, sw_ok, sw_prev, next_sw_ok, rise;
  logic [$bits(pms_pkg::pms_sw_s)-1:0] agree;

  always_comb
  begin
    agree      = ~(sw_q2 ^ sw_q3);
    next_sw_ok = pms_pkg::pms_sw_s'((sw_q2 & agree) | (sw_ok & ~agree));
    rise       = pms_pkg::pms_sw_s'(sw_ok & ~sw_prev);
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    sw_q1   <= I_SW;
    sw_q2   <= sw_q1;
    sw_q3   <= sw_q2;
    if (I_RST)
    begin
      sw_ok   <= '0;
      sw_prev <= '0;
    end
    else
    begin
      sw_ok   <= next_sw_ok;
      sw_prev <= sw_ok;
    end
  end

  pms_pkg::pms_state_e state, next_state;
  pms_pkg::pms_psw_s   psw, next_psw;
  pms_pkg::pms_mem_s   mem, next_mem;
  logic [31:0] d, a, b, ctrl, prdata;
  logic [31:0] next_d, next_a, next_b, next_ctrl, next_prdata, sum;
  logic [16:0] p, next_p, clr_addr, next_clr_addr;
  logic        halt, io_service_call_flag, ins_second, exec_start, mem_clear, pslverr;
  logic        next_halt, next_io_service_call_flag, next_ins_second, next_exec_start, next_mem_clear;
  logic        next_pslverr, idle_ok, go_clrmem, go_insert, go_enter, go_dclear, go_store;
  logic        go_display, go_incr, go_compute, apb_wr;

  always_comb
  begin
    idle_ok    = (state == pms_pkg::ST_IDLE) && !ctrl[pms_pkg::CTRL_LOCK];
    go_clrmem  = idle_ok && sw_ok.cpu_reset_clear && sw_ok.sys_reset_clear;
    go_insert  = idle_ok && !go_clrmem
                 && (sw_ok.insert_first_status_select || sw_ok.insert_second_status_select)
                 && sw_ok.panel_action_strobe_first && sw_ok.panel_action_strobe_second
                 && (rise.panel_action_strobe_first || rise.panel_action_strobe_second);
    go_enter   = idle_ok && !go_clrmem && !go_insert && rise.data_enter;
    go_dclear  = idle_ok && !go_clrmem && !go_insert && !go_enter && rise.data_clear;
    go_store   = idle_ok && !go_clrmem && !go_insert && !go_enter && !go_dclear
                 && (rise.store_instr_addr || rise.store_sel_addr);
    go_display = idle_ok && !go_clrmem && !go_insert && !go_enter && !go_dclear && !go_store
                 && (rise.display_instr_addr || rise.display_sel_addr);
    go_incr    = idle_ok && !go_clrmem && !go_insert && !go_enter && !go_dclear && !go_store
                 && !go_display && rise.address_increment_request;
    go_compute = idle_ok && !go_clrmem && !go_insert && !go_enter && !go_dclear && !go_store
                 && !go_display && !go_incr && (rise.compute_run || rise.compute_step);
    apb_wr     = I_PSEL && I_PENABLE && I_PWRITE && addr_mapped(I_PADDR);
    sum        = a | d;

    next_state      = state;
    next_d          = d;
    next_a          = a;
    next_b          = b;
    next_p          = p;
    next_psw        = psw;
    next_mem        = mem;
    next_halt       = halt;
    next_io_service_call_flag       = io_service_call_flag;
    next_ins_second = ins_second;
    next_exec_start = 1'b0;
    next_mem_clear  = mem_clear;
    next_clr_addr   = clr_addr;
    next_ctrl       = ctrl;

    if (apb_wr && I_PADDR == pms_pkg::REG_CTRL)
      next_ctrl = I_PWDATA;
    if (apb_wr && I_PADDR == pms_pkg::REG_IADDR)
      next_p = I_PWDATA[16:0];

    unique case (state)
      pms_pkg::ST_IDLE:
      begin
        if (go_clrmem)
        begin
          next_mem_clear = 1'b1;
          next_clr_addr  = pms_pkg::ADDR_ZERO;
          next_d         = pms_pkg::ZERO_WORD;
          next_mem       = '{req: 1'b1, we: 1'b1, addr: pms_pkg::ADDR_ZERO,
                             wdata: pms_pkg::ZERO_WORD};
          next_state     = pms_pkg::ST_CLR;
        end
        else if (go_insert)
        begin
          next_halt       = 1'b0;
          next_ins_second = !sw_ok.insert_first_status_select;
          next_state      = pms_pkg::ST_PH3;
        end
        else if (go_enter)
          next_d = sw_ok.data_switch_outputs;
        else if (go_dclear)
          next_d = pms_pkg::ZERO_WORD;
        else if (go_store)
        begin
          // selected-address switch wins if both positions read active
          next_mem = '{req: 1'b1, we: 1'b1, wdata: d,
                       addr: rise.store_sel_addr ? sw_ok.sel_addr : p};
          next_state = pms_pkg::ST_MEM;
        end
        else if (go_display)
        begin
          next_mem = '{req: 1'b1, we: 1'b0, wdata: pms_pkg::ZERO_WORD,
                       addr: rise.display_sel_addr ? sw_ok.sel_addr : p};
          next_state = pms_pkg::ST_MEM;
        end
        else if (go_incr)
        begin
          next_p   = p + pms_pkg::ADDR_ONE;
          next_mem = '{req: 1'b1, we: 1'b0, wdata: pms_pkg::ZERO_WORD,
                       addr: p + pms_pkg::ADDR_ONE};
          next_state = pms_pkg::ST_MEM;
        end
        else if (go_compute)
        begin
          next_halt       = 1'b0;
          next_exec_start = 1'b1;
          next_state      = pms_pkg::ST_EXEC;
        end
      end
      pms_pkg::ST_PH3:
      begin
        next_b = d;
        next_a = ins_second ? second_status_word_word(psw) : first_status_word_word(psw);
        if (!I_IO_FUNCTION_STROBE)
          next_io_service_call_flag = 1'b0;
        next_state = pms_pkg::ST_PH4;
      end
      pms_pkg::ST_PH4:
      begin
        next_d = ins_second ? a : {p, a[pms_pkg::P_FIELD_LO-1:0]};
        next_a = sw_ok.data_switch_outputs;
        next_state = pms_pkg::ST_PH5;
      end
      pms_pkg::ST_PH5:
      begin
        // or-ing keeps ones already present, so an insert never clears a bit
        if (!ins_second)
        begin
          next_psw.condition_code_bits    = psw.condition_code_bits
                                            | sum[pms_pkg::P1_CC_LO +: 4];
          next_psw.float_significance_bit = psw.float_significance_bit | sum[pms_pkg::P1_FS];
          next_psw.float_zero_bit         = psw.float_zero_bit | sum[pms_pkg::P1_FZ];
          next_psw.float_normalize_bit    = psw.float_normalize_bit | sum[pms_pkg::P1_FNF];
          next_psw.slave_mode_bit         = psw.slave_mode_bit | sum[pms_pkg::P1_SLAVE];
          next_psw.decimal_mask_bit       = psw.decimal_mask_bit | sum[pms_pkg::P1_DM];
          next_psw.arith_mask_bit         = psw.arith_mask_bit | sum[pms_pkg::P1_AM];
        end
        else
        begin
          next_psw.write_key_bit_zero     = psw.write_key_bit_zero | sum[pms_pkg::P2_WK0];
          next_psw.write_key_bit_one      = psw.write_key_bit_one | sum[pms_pkg::P2_WK1];
          next_psw.counter_inhibit_bit    = psw.counter_inhibit_bit | sum[pms_pkg::P2_CI];
          next_psw.io_inhibit_bit         = psw.io_inhibit_bit | sum[pms_pkg::P2_II];
          next_psw.external_inhibit_bit   = psw.external_inhibit_bit | sum[pms_pkg::P2_EI];
          next_psw.register_pointer_field = psw.register_pointer_field
                                            | sum[pms_pkg::P2_RP_LO +: 4];
        end
        next_state = pms_pkg::ST_PH6;
      end
      pms_pkg::ST_PH6:
      begin
        next_d     = b;
        next_halt  = 1'b1;
        next_state = pms_pkg::ST_PH1;
      end
      pms_pkg::ST_PH1:
        next_state = pms_pkg::ST_IDLE;
      pms_pkg::ST_MEM, pms_pkg::ST_FETCH:
      begin
        if (I_MEM_ACK)
        begin
          next_mem.req = 1'b0;
          if (!mem.we)
            next_d = I_MEM_RDATA;
          if (state == pms_pkg::ST_FETCH)
          begin
            next_exec_start = 1'b1;
            next_state      = pms_pkg::ST_EXEC;
          end
          else
            next_state = pms_pkg::ST_IDLE;
        end
      end
      pms_pkg::ST_CLR:
      begin
        if (I_MEM_ACK)
        begin
          if (clr_addr == LAST_ADDR)
          begin
            next_mem.req   = 1'b0;
            next_mem_clear = 1'b0;
            next_state     = pms_pkg::ST_IDLE;
          end
          else
          begin
            next_clr_addr = clr_addr + pms_pkg::ADDR_ONE;
            next_mem.addr = clr_addr + pms_pkg::ADDR_ONE;
          end
        end
      end
      pms_pkg::ST_EXEC:
      begin
        if (I_EXEC_DONE)
        begin
          // hold keeps the address so a running loop refetches the same word
          next_p = sw_ok.address_hold_request ? p : p + pms_pkg::ADDR_ONE;
          if (sw_ok.compute_run && !halt && !I_HALT_REQ)
          begin
            next_mem   = '{req: 1'b1, we: 1'b0, wdata: pms_pkg::ZERO_WORD, addr: next_p};
            next_state = pms_pkg::ST_FETCH;
          end
          else
            next_state = pms_pkg::ST_PH1;
        end
      end
    endcase

    // set wins over a same-cycle clear
    if (I_HALT_REQ)
      next_halt = 1'b1;
    if (I_IO_SERVICE_CALL)
      next_io_service_call_flag = 1'b1;

    next_pslverr = !addr_mapped(I_PADDR);
    unique case (I_PADDR)
      pms_pkg::REG_CTRL:    next_prdata = ctrl;
      pms_pkg::REG_STATUS:  next_prdata = {27'h000_0000, state == pms_pkg::ST_EXEC, mem_clear,
                                           io_service_call_flag, halt, state == pms_pkg::ST_IDLE};
      pms_pkg::REG_DISPLAY: next_prdata = d;
      pms_pkg::REG_IADDR:   next_prdata = {15'h0000, p};
      pms_pkg::REG_FIRST_STATUS_WORD:    next_prdata = first_status_word_word(psw);
      pms_pkg::REG_SECOND_STATUS_WORD:    next_prdata = second_status_word_word(psw);
      pms_pkg::REG_AREG:    next_prdata = a;
      pms_pkg::REG_BREG:    next_prdata = b;
      default:              next_prdata = pms_pkg::ZERO_WORD;
    endcase
    if (!(I_PSEL && !I_PENABLE))
    begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      state      <= pms_pkg::ST_IDLE;
      d          <= pms_pkg::ZERO_WORD;
      a          <= pms_pkg::ZERO_WORD;
      b          <= pms_pkg::ZERO_WORD;
      p          <= pms_pkg::ADDR_ZERO;
      psw        <= '0;
      mem        <= '0;
      halt       <= 1'b1;
      io_service_call_flag       <= 1'b0;
      ins_second <= 1'b0;
      exec_start <= 1'b0;
      mem_clear  <= 1'b0;
      clr_addr   <= pms_pkg::ADDR_ZERO;
      ctrl       <= pms_pkg::CTRL_RST;
      prdata     <= pms_pkg::ZERO_WORD;
      pslverr    <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      d          <= next_d;
      a          <= next_a;
      b          <= next_b;
      p          <= next_p;
      psw        <= next_psw;
      mem        <= next_mem;
      halt       <= next_halt;
      io_service_call_flag       <= next_io_service_call_flag;
      ins_second <= next_ins_second;
      exec_start <= next_exec_start;
      mem_clear  <= next_mem_clear;
      clr_addr   <= next_clr_addr;
      ctrl       <= next_ctrl;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
    end
  end

  assign O_PRDATA     = prdata;
  assign O_PREADY     = 1'b1;
  assign O_PSLVERR    = pslverr && I_PSEL && I_PENABLE;
  assign O_EXEC_START = exec_start;
  assign O_EXEC_INSTR = d;
  assign O_MEM        = mem;
  assign O_DISPLAY    = d;
  assign O_INSTR_ADDR = p;
  assign O_HALT       = halt;
  assign O_MEM_CLEAR  = mem_clear;
  assign O_IDLE_PHASE = (state == pms_pkg::ST_IDLE);

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  property p_enter;
    go_enter |=> d == $past(sw_ok.data_switch_outputs);
  endproperty
  a_enter: assert property (p_enter) else $error("enter did not load switches");
  property p_dclear;
    go_dclear |=> d == pms_pkg::ZERO_WORD;
  endproperty
  a_dclear: assert property (p_dclear) else $error("clear did not zero display");
  property p_store_idle;
    state != pms_pkg::ST_IDLE && state != pms_pkg::ST_MEM |=> state != pms_pkg::ST_MEM;
  endproperty
  a_store_idle: assert property (p_store_idle) else $error("store outside idle");
  property p_addr_step;
    state == pms_pkg::ST_EXEC && I_EXEC_DONE
      |=> p == ($past(sw_ok.address_hold_request) ? $past(p) : 17'($past(p) + 1));
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address step wrong");
  property p_insert_start;
    go_insert && !I_HALT_REQ |=> state == pms_pkg::ST_PH3 && !halt;
  endproperty
  a_insert_start: assert property (p_insert_start) else $error("insert start wrong");
  property p_ph3;
    state == pms_pkg::ST_PH3 |=> b == $past(d)
      && a == ($past(ins_second) ? second_status_word_word($past(psw)) : first_status_word_word($past(psw)));
  endproperty
  a_ph3: assert property (p_ph3) else $error("phase 3 transfer wrong");
  property p_io_service_call_flag;
    state == pms_pkg::ST_PH3 && !I_IO_FUNCTION_STROBE && !I_IO_SERVICE_CALL |=> !io_service_call_flag;
  endproperty
  a_io_service_call_flag: assert property (p_io_service_call_flag) else $error("service call not cleared");
  property p_ph4;
    state == pms_pkg::ST_PH4 |=> a == $past(sw_ok.data_switch_outputs)
      && d[pms_pkg::P_FIELD_LO-1:0] == $past(a[pms_pkg::P_FIELD_LO-1:0])
      && ($past(ins_second) || d[pms_pkg::DATA_W-1:pms_pkg::P_FIELD_LO] == $past(p));
  endproperty
  a_ph4: assert property (p_ph4) else $error("phase 4 transfer wrong");
  property p_ph6;
    state == pms_pkg::ST_PH6 |=> halt && d == $past(b) && state == pms_pkg::ST_PH1
      ##1 state == pms_pkg::ST_IDLE;
  endproperty
  a_ph6: assert property (p_ph6) else $error("phase 6 or 1 wrong");
endmodule

/* File: verif/pms_mem_model.sv */
// core memory stand-in: acks each request after a latency that cycles between prompt and slow
module pms_mem_model #(
  parameter int WORDS = 16
) (
  input  wire logic             clk,
  input  wire pms_pkg::pms_mem_s mem,
  output logic                  ack,
  output logic [31:0]           rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] store [WORDS];
  int          cnt  = 0;
  int          slow = 0;
  initial
  begin
    ack   = 1'b0;
    rdata = 32'h0000_0000;
    for (int i = 0; i < WORDS; i++) store[i] = 32'hA5A5_0000 | i;
  end
  always @(posedge clk)
  begin
    if (mem.req && !ack && cnt >= slow)
    begin
      ack  <= 1'b1;
      cnt  <= 0;
      slow <= (slow + 3) % 5;
      if (mem.we) store[mem.addr % WORDS] <= mem.wdata;
      // read data only means something alongside ack
      rdata <= mem.we ? ~rdata : store[mem.addr % WORDS];
    end
    else
    begin
      ack   <= 1'b0;
      rdata <= ~rdata;
      if (mem.req && !ack) cnt <= cnt + 1;
    end
  end
endmodule

/* File: verif/panel_maintenance_sequencer_tb.sv */
// self-checking bench: switch actions, apb readback through an expectation queue
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module panel_maintenance_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, done = 0, iocall = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata, v1, v2, seed = 32'h0000_3f20;
  logic        pready, pslverr, ack, start;
  pms_pkg::pms_sw_s  sw = '0, base = '0, v;
  pms_pkg::pms_mem_s mbus;
  logic        idle, mclr;
  logic [32:0] exp_q [$];
  int          failures = 0, check_count = 0;
  logic        iofs = 0, halt;
  logic [31:0] instr, disp, ins_v, ins_q [$];
  logic [16:0] iaddr;
  logic [32:0] exp_v;
  always #5 clk = ~clk;
  always @(posedge clk) done <= start;
  pms_sequencer #(.MEM_WORDS(16)) dut (.I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SW(sw), .I_IO_FUNCTION_STROBE(iofs),
    .I_IO_SERVICE_CALL(iocall), .I_HALT_REQ(1'b0), .I_EXEC_DONE(done), .O_EXEC_START(start),
    .O_EXEC_INSTR(instr), .O_MEM(mbus), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata),
    .O_DISPLAY(disp), .O_INSTR_ADDR(iaddr), .O_HALT(halt), .O_MEM_CLEAR(mclr),
    .O_IDLE_PHASE(idle));
  pms_mem_model #(.WORDS(16)) mem (.clk(clk), .mem(mbus), .ack(ack), .rdata(rdata));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic tally_and_finish();
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0; pen <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0000_0000);
  endtask
  // sync stages delay action start, so wait a little before polling idle
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    while (!(idle === 1'b1 && mbus.req === 1'b0 && mclr === 1'b0) && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    // a hung action still ends the wait, but counts against the run
    if (n >= 3000)
      failures++;
  endtask
  task automatic flip(input pms_pkg::pms_sw_s f);
    sw <= f; settle(); sw <= base; settle();
  endtask
  // pop once per read: the macro names its arguments more than once
  always @(posedge clk)
    if (psel && pen && pready && !pwr)
    begin
      exp_v = exp_q.pop_front();
      `CHK("prdata", exp_v, {pslverr, prdata})
      if (paddr == pms_pkg::REG_DISPLAY) `CHK("display", exp_v[31:0], disp)
      if (paddr == pms_pkg::REG_IADDR) `CHK("instr_addr", exp_v[16:0], iaddr)
      if (paddr == pms_pkg::REG_STATUS) `CHK("halt", exp_v[1], halt)
    end
  // only noted starts are compared; a running loop starts unnoted ones
  always @(posedge clk)
    if (start === 1'b1 && ins_q.size() != 0)
    begin
      ins_v = ins_q.pop_front();
      `CHK("exec_instr", ins_v, instr)
    end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 0;
    rd(pms_pkg::REG_STATUS, 33'h0_0000_0003);
    rd(8'h20, 33'h1_0000_0000);
    seed = xs(seed); v1 = seed; seed = xs(seed); v2 = seed;
    base.data_switch_outputs = v1; base.sel_addr = 17'h0_0005; sw <= base; settle();
    v = base; v.data_enter = 1; flip(v);
    rd(pms_pkg::REG_DISPLAY, {1'b0, v1});
    v = base; v.store_sel_addr = 1; flip(v);
    v = base; v.data_clear = 1; flip(v);
    rd(pms_pkg::REG_DISPLAY, 33'h0);
    v = base; v.display_sel_addr = 1; flip(v);
    rd(pms_pkg::REG_DISPLAY, {1'b0, v1});
    // locked panel ignores switch actions
    apb(1, pms_pkg::REG_CTRL, 32'h0000_0001);
    v = base; v.data_clear = 1; flip(v);
    rd(pms_pkg::REG_CTRL, 33'h0_0000_0001);
    rd(pms_pkg::REG_DISPLAY, {1'b0, v1});
    apb(1, pms_pkg::REG_CTRL, 32'h0000_0000);
    apb(1, pms_pkg::REG_IADDR, 32'h0000_0003);
    v = base; v.store_instr_addr = 1; flip(v);
    v = base; v.data_clear = 1; flip(v);
    v = base; v.display_instr_addr = 1; flip(v);
    rd(pms_pkg::REG_DISPLAY, {1'b0, v1});
    v = base; v.address_increment_request = 1; flip(v);
    rd(pms_pkg::REG_IADDR, 33'h0_0000_0004);
    rd(pms_pkg::REG_DISPLAY, 33'h0_A5A5_0004);
    ins_q.push_back(32'hA5A5_0004);
    v = base; v.compute_step = 1; flip(v);
    rd(pms_pkg::REG_IADDR, 33'h0_0000_0005);
    v = base; v.insert_first_status_select = 1; v.panel_action_strobe_first = 1;
    v.panel_action_strobe_second = 1; flip(v);
    rd(pms_pkg::REG_FIRST_STATUS_WORD, {1'b0, v1 & 32'h0000_0DEF});
    rd(pms_pkg::REG_DISPLAY, 33'h0_A5A5_0004);
    rd(pms_pkg::REG_STATUS, 33'h0_0000_0003);
    base.data_switch_outputs = v2; v.data_switch_outputs = v2; flip(v);
    rd(pms_pkg::REG_FIRST_STATUS_WORD, {1'b0, (v1 | v2) & 32'h0000_0DEF});
    iocall <= 1;
    iofs <= 1;
    @(posedge clk);
    iocall <= 0;
    v.insert_first_status_select = 0; v.insert_second_status_select = 1; flip(v);
    rd(pms_pkg::REG_SECOND_STATUS_WORD, {1'b0, v2 & 32'h0F00_00EC});
    rd(pms_pkg::REG_STATUS, 33'h0_0000_0007);
    iofs <= 0;
    flip(v);
    rd(pms_pkg::REG_STATUS, 33'h0_0000_0003);
    // hold with run keeps refetching address 5, which holds v1
    v = base; v.address_hold_request = 1; v.compute_run = 1;
    sw <= v;
    repeat (40) @(posedge clk);
    v.compute_run = 0; flip(v);
    rd(pms_pkg::REG_IADDR, 33'h0_0000_0005);
    rd(pms_pkg::REG_DISPLAY, {1'b0, v1});
    v = base; v.cpu_reset_clear = 1; v.sys_reset_clear = 1;
    sw <= v;
    repeat (8) @(posedge clk);
    `CHK("mem_clear", 1'b1, mclr)
    settle(); sw <= base; settle();
    v = base; v.data_enter = 1; flip(v);
    v = base; v.display_sel_addr = 1; flip(v);
    rd(pms_pkg::REG_DISPLAY, 33'h0);
    // let the last read's compare run before the verdict
    @(posedge clk);
    if (ins_q.size() != 0)
      failures++;
    tally_and_finish();
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
